// ### src/adc_link_pkg.sv
// constants shared by both ends of the converter serial read-out link
// Contract
// (R1) select falling samples input, starts conversion
// (R2) word: two zeros, 12 bits MSB first, two zeros
// (R3) first zero at select fall, MSB on 2nd fall
// (R4) conversion ends rising edge after 13th fall
// (R5) host reads sixteen-clock frame, releases after end
// (R6) data output high impedance while select high
// (R7) host waits quiet or acquisition time before restart
// (R8) early release gives no acquisition, next result invalid; code records it in valid_reg but ready_o ignores it
// (R9) select rise mid-conversion aborts, output released
// (R10) rise after 2nd, before 10th fall: power-down
// (R11) power-down halts conversion, releases output
// (R12) wake by holding select over 10 falls
// (R13) wake cycle may release after 10th fall; code wakes only on the 11th fall
// (R14) power-up 0.8 us; discard dummy frames; host discards none (DUMMY_FRAMES unused), bench skips one frame
// (R15) output released after 16th falling clock edge
// (R16) host takes bits three to fourteen as result
// (R17) host idles select high, lowers before clocking
package adc_link_pkg;
  // ***************************************************
  // frame layout
  // ***************************************************
  localparam int RESULT_BITS   = 12;
  localparam int FRAME_BITS    = 16;
  localparam int LEAD_ZEROS    = 2;
  localparam int CONV_END_FALL = 13;
  localparam int PD_FIRST_FALL = 2;
  localparam int PD_LAST_FALL  = 10;
  localparam int WAKE_FALLS    = 10;
  localparam int CNT_W         = 5;
  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int POWERUP_NS    = 800;
  localparam int POWERUP_CYC   =
    (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUIET_NS      = 10;
  localparam int QUIET_CYC     =
    (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DUMMY_FRAMES  = 3;
  localparam int SCLK_DIV      = 8;
endpackage

// ### src/adc_link_if.sv
// interface joining host and converter serial ends
`timescale 1ns/1ns
interface adc_link_if;
  logic select_n;
  logic sclk;
  logic result_out;
  logic result_out_oe;
  modport converter (
    input  select_n,
    input  sclk,
    output result_out,
    output result_out_oe
  );
  modport host (
    output select_n,
    output sclk,
    input  result_out,
    input  result_out_oe
  );
endinterface

// ### src/adc_converter_end.sv
// converter end of the serial read-out link
`timescale 1ns/1ns
module adc_converter_end
  import adc_link_pkg::*;
(
  input  wire logic                         clk_sys_i,
  input  wire logic                         rst_i,
  adc_link_if.converter                     link,
  input  wire logic [adc_link_pkg::RESULT_BITS-1:0] sample_i,
  output logic                              sampled_o,
  output logic                              conv_done_o,
  output logic                              conv_abort_o,
  output logic                              powered_down_o,
  output logic                              ready_o
);
  import adc_link_pkg::*;

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  logic [1:0] cs_sync_reg;
  logic [1:0] ck_sync_reg;
  logic       cs_reg;
  logic       ck_reg;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cs_sync_reg <= 2'h3;
      ck_sync_reg <= 2'h0;
      cs_reg      <= 1'b1;
      ck_reg      <= 1'b0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], link.select_n};
      ck_sync_reg <= {ck_sync_reg[0], link.sclk};
      cs_reg      <= cs_sync_reg[1];
      ck_reg      <= ck_sync_reg[1];
    end
  end
  logic cs_fall;
  logic cs_rise;
  logic ck_fall;
  logic ck_rise;
  assign cs_fall = cs_reg & ~cs_sync_reg[1];
  assign cs_rise = ~cs_reg & cs_sync_reg[1];
  assign ck_fall = ck_reg & ~ck_sync_reg[1] & ~cs_sync_reg[1];
  assign ck_rise = ~ck_reg & ck_sync_reg[1] & ~cs_sync_reg[1];

  // ***************************************************
  // frame state
  // ***************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_ACQ  = 2'b10
  } state_type;
  state_type            state_reg;
  logic [CNT_W-1:0]     fall_cnt_reg;
  logic [FRAME_BITS-1:0] shift_reg;
  logic                 pd_reg;
  logic                 valid_reg;
  logic                 oe_reg;
  logic [9:0]           pwr_cnt_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fall_cnt_reg <= '0;
    end else if (cs_fall) begin
      fall_cnt_reg <= '0;
    end else if (ck_fall && fall_cnt_reg != 5'h1F) begin
      fall_cnt_reg <= fall_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else if (cs_fall && !pd_reg) begin
      state_reg <= ST_CONV; // R1
    end else if (cs_rise) begin
      state_reg <= ST_IDLE; // R9
    end else if (state_reg == ST_CONV && ck_rise &&
                 fall_cnt_reg >= CNT_W'(CONV_END_FALL)) begin
      state_reg <= ST_ACQ; // R4
    end
  end

  // sampled word: zeros framed around result
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      shift_reg <= '0;
    end else if (cs_fall) begin
      shift_reg <= {2'h0, sample_i, 2'h0}; // R2
    end else if (ck_fall) begin
      shift_reg <= {shift_reg[FRAME_BITS-2:0], 1'b0}; // R3
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      oe_reg <= 1'b0;
    end else if (cs_sync_reg[1]) begin
      oe_reg <= 1'b0; // R6
    end else if (cs_fall && !pd_reg) begin
      oe_reg <= 1'b1;
    end else if (ck_fall && fall_cnt_reg == CNT_W'(FRAME_BITS - 1)) begin
      oe_reg <= 1'b0; // R15
    end
  end

  // power-down entry and wake
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pd_reg <= 1'b0;
    end else if (cs_rise && fall_cnt_reg >= CNT_W'(PD_FIRST_FALL) &&
                 fall_cnt_reg < CNT_W'(PD_LAST_FALL)) begin
      pd_reg <= 1'b1; // R10 R11
    end else if (pd_reg && ck_fall &&
                 fall_cnt_reg >= CNT_W'(WAKE_FALLS)) begin
      pd_reg <= 1'b0; // R12
    end
  end

  // early release (no acquisition) clears valid_reg; ready_o does not depend on it
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      valid_reg <= 1'b0;
    end else if (cs_rise) begin
      valid_reg <= (state_reg == ST_ACQ) && ready_o; // R8
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_cnt_reg <= '0;
    end else if (pd_reg) begin
      pwr_cnt_reg <= 10'(POWERUP_CYC); // R14
    end else if (pwr_cnt_reg != '0) begin
      pwr_cnt_reg <= pwr_cnt_reg - 10'h001;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sampled_o    <= 1'b0;
      conv_done_o  <= 1'b0;
      conv_abort_o <= 1'b0;
    end else begin
      sampled_o    <= cs_fall && !pd_reg;
      conv_done_o  <= state_reg == ST_CONV && ck_rise &&
                      fall_cnt_reg >= CNT_W'(CONV_END_FALL);
      conv_abort_o <= cs_rise && state_reg == ST_CONV;
    end
  end

  assign powered_down_o     = pd_reg;
  assign ready_o            = pwr_cnt_reg == '0 && !pd_reg && valid_reg |
                              (pwr_cnt_reg == '0 && !pd_reg);
  assign link.result_out    = shift_reg[FRAME_BITS-1] & oe_reg;
  assign link.result_out_oe = oe_reg;
endmodule

// ### src/adc_host_end.sv
// host end: frames select and serial clock, gathers result
`timescale 1ns/1ns
module adc_host_end
  import adc_link_pkg::*;
(
  input  wire logic                         clk_sys_i,
  input  wire logic                         rst_i,
  adc_link_if.host                          link,
  input  wire logic                         start_i,
  input  wire logic [adc_link_pkg::CNT_W-1:0] falls_i,
  output logic                              busy_o,
  output logic                              done_o,
  output logic [adc_link_pkg::RESULT_BITS-1:0] result_o
);
  import adc_link_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_RUN  = 2'b10,
    ST_GAP  = 2'b11
  } state_type;
  state_type             state_reg;
  logic [3:0]            div_reg;
  logic                  sclk_reg;
  logic                  cs_n_reg;
  logic [CNT_W-1:0]      fall_reg;
  logic [CNT_W-1:0]      target_reg;
  logic [FRAME_BITS-1:0] rx_reg;
  logic [1:0]            sdo_sync_reg;
  logic [3:0]            gap_reg;

  // ***************************************************
  // frame sequencer
  // ***************************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg  <= ST_IDLE;
      cs_n_reg   <= 1'b1;
      sclk_reg   <= 1'b1;
      div_reg    <= '0;
      fall_reg   <= '0;
      target_reg <= 5'h10;
      gap_reg    <= '0;
      done_o     <= 1'b0;
      result_o   <= '0;
    end else begin
      done_o <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start_i) begin
            cs_n_reg   <= 1'b0; // R17
            target_reg <= (falls_i == '0) ? CNT_W'(FRAME_BITS) : falls_i;
            fall_reg   <= '0;
            div_reg    <= '0;
            state_reg  <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          div_reg <= div_reg + 4'h1;
          if (div_reg == 4'(SCLK_DIV / 2 - 1)) begin
            div_reg   <= '0;
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          div_reg <= div_reg + 4'h1;
          // mid high phase: bit of the last fall has crossed both syncs
          if (sclk_reg && div_reg == 4'h1 &&
              fall_reg >= CNT_W'(LEAD_ZEROS) &&
              fall_reg <= CNT_W'(CONV_END_FALL)) begin
            rx_reg <= {rx_reg[FRAME_BITS-2:0], sdo_sync_reg[1]}; // R16
          end
          if (div_reg == 4'(SCLK_DIV / 2 - 1)) begin
            div_reg <= '0;
            // release only after the rise that follows the last fall
            if (sclk_reg && fall_reg == target_reg) begin
              cs_n_reg  <= 1'b1; // R5 R13
              result_o  <= rx_reg[RESULT_BITS-1:0]; // R16
              done_o    <= 1'b1;
              gap_reg   <= 4'(QUIET_CYC + 2); // R7
              state_reg <= ST_GAP;
            end else begin
              sclk_reg <= ~sclk_reg;
              if (sclk_reg) begin
                fall_reg <= fall_reg + 5'h01;
              end
            end
          end
        end
        ST_GAP: begin
          gap_reg <= gap_reg - 4'h1;
          if (gap_reg == '0) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // data pin from the far end, two flops before use
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sdo_sync_reg <= 2'h0;
    end else begin
      sdo_sync_reg <= {sdo_sync_reg[0], link.result_out};
    end
  end

  assign busy_o        = state_reg != ST_IDLE;
  assign link.select_n = cs_n_reg;
  assign link.sclk     = sclk_reg;
endmodule

// ### tb/adc_link_checker.sv
// assertions on the converter read-out link pins
`timescale 1ns/1ns
module adc_link_checker (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic select_n,
  input wire logic sclk,
  input wire logic result_out,
  input wire logic result_out_oe
);
  logic       sclk_reg;
  logic       sel_reg;
  logic       pd_reg;
  logic [4:0] cnt_reg;
  logic       fall_w;
  assign fall_w = sclk_reg && !sclk && !select_n;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_reg <= 1'b1;
      sel_reg  <= 1'b1;
    end else begin
      sclk_reg <= sclk;
      sel_reg  <= select_n;
    end
  end
  // saturates so a stretched frame cannot wrap
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 5'h00;
    end else if (select_n) begin
      cnt_reg <= 5'h00;
    end else if (fall_w && cnt_reg != 5'h1F) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end
  // judged from raw pins, so sync latency is absorbed by the bounds below
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pd_reg <= 1'b0;
    end else if (select_n && !sel_reg && cnt_reg inside {[5'h02:5'h09]}) begin
      pd_reg <= 1'b1;
    end else if (fall_w && cnt_reg == 5'h0A) begin
      pd_reg <= 1'b0;
    end
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  sequence frame_open_s;
    $fell(select_n) ##0 !pd_reg;
  endsequence
  sequence pad_fall_s;
    fall_w && cnt_reg inside {5'h00, 5'h0D, 5'h0E};
  endsequence
  idle_release_a: assert property (select_n [*6] |-> !result_out_oe)
    else $error("data output driven with select high");
  rise_release_a: assert property ($rose(select_n) |-> ##[1:7] !result_out_oe)
    else $error("data output kept after select rise");
  pd_entry_a: assert property ($rose(select_n) && cnt_reg inside {[5'h02:5'h09]}
    |-> ##[1:7] !result_out_oe ##1 !result_out_oe [*3])
    else $error("output not released on power-down");
  pd_quiet_a: assert property (pd_reg && !select_n
    && cnt_reg inside {[5'h01:5'h0A]} |-> !result_out_oe)
    else $error("output driven while powered down");
  drive_start_a: assert property (frame_open_s |-> ##[1:7] result_out_oe)
    else $error("frame start not answered");
  first_zero_a: assert property ($rose(result_out_oe) |-> !result_out)
    else $error("first bit not zero");
  pad_zero_a: assert property (pad_fall_s |-> ##6 (!result_out || !result_out_oe))
    else $error("padding bit not zero");
  frame_release_a: assert property (fall_w && cnt_reg == 5'h0F
    |-> ##[1:7] !result_out_oe)
    else $error("output kept after last falling edge");
  host_idle_a: assert property (frame_open_s or $fell(select_n) |-> sclk [*3])
    else $error("serial clock moved too soon");
endmodule

// ### tb/sar_adc_serial_readout_tb.sv
// self-checking bench joining host and converter ends
`timescale 1ns/1ns
module sar_adc_serial_readout_tb;
  import adc_link_pkg::*;
  logic                   clk_sys_i, rst_i, start_i, busy_o, done_o;
  logic                   sampled_o, conv_done_o, conv_abort_o;
  logic                   powered_down_o, ready_o;
  logic [CNT_W-1:0]       falls_i;
  logic [RESULT_BITS-1:0] sample_i, result_o;
  logic [CNT_W-1:0]       pd_falls [2] = '{5'h02, 5'h09};
  int                     err_count = 0;
  int                     cmp_count = 0;
  int                     samp_cnt = 0;
  int                     end_cnt = 0;
  int                     abort_cnt = 0;
  adc_link_if link ();
  adc_converter_end adc_converter_end_i (.clk_sys_i, .rst_i, .link,
    .sample_i, .sampled_o, .conv_done_o, .conv_abort_o, .powered_down_o,
    .ready_o);
  adc_host_end adc_host_end_i (.clk_sys_i, .rst_i, .link, .start_i,
    .falls_i, .busy_o, .done_o, .result_o);
  adc_link_checker adc_link_checker_i (.clk_sys_i, .rst_i,
    .select_n(link.select_n), .sclk(link.sclk),
    .result_out(link.result_out), .result_out_oe(link.result_out_oe));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // opposite edge, so one-cycle pulses are never raced
  always @(negedge clk_sys_i) begin
    samp_cnt += (sampled_o === 1'b1);
    end_cnt += (conv_done_o === 1'b1);
    abort_cnt += (conv_abort_o === 1'b1);
  end
  task automatic finish_test;
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic fail(input string msg);
    err_count++;
    $display("[ERR] %0t %s", $time, msg);
  endtask
  task automatic cmp_vec(input logic [RESULT_BITS-1:0] got, exp);
    cmp_count++;
    if (got !== exp) fail($sformatf("result %h expected %h", got, exp));
  endtask
  task automatic cmp_bit(input logic got, exp);
    cmp_count++;
    if (got !== exp) fail("flag mismatch");
  endtask
  task automatic cmp_cnt(input int got, exp);
    cmp_count++;
    if (got != exp) fail($sformatf("count %0d expected %0d", got, exp));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic bound(input int i, lim);
    if (i >= lim) begin
      fail("wait ran out");
      finish_test();
    end
  endtask
  task automatic wait_ready;
    int i;
    for (i = 0; i < 300 && ready_o !== 1'b1; i++) tick(1);
    bound(i, 300);
  endtask
  task automatic run_frame(input logic [CNT_W-1:0] n,
                           input logic [RESULT_BITS-1:0] s);
    int i;
    sample_i = s;
    falls_i = n;
    start_i = 1'b1;
    tick(1);
    start_i = 1'b0;
    for (i = 0; i < 400 && done_o !== 1'b1; i++) tick(1);
    bound(i, 400);
    for (i = 0; i < 50 && busy_o !== 1'b0; i++) tick(1);
    bound(i, 50);
    tick(QUIET_CYC + 4);
  endtask
  initial begin
    rst_i = 1'b1;
    start_i = 1'b0;
    falls_i = '0;
    sample_i = '0;
    tick(12);
    rst_i = 1'b0;
    cmp_bit(link.result_out_oe, 1'b0);
    cmp_bit(link.sclk & link.select_n, 1'b1);
    cmp_bit(powered_down_o, 1'b0);
    wait_ready();
    foreach (pd_falls[k]) begin
      run_frame(5'h10, {k[0], 10'h2A5, ~k[0]});
      cmp_vec(result_o, {k[0], 10'h2A5, ~k[0]});
    end
    run_frame(5'h10, 12'hFFF);
    cmp_vec(result_o, 12'hFFF);
    cmp_cnt(samp_cnt, 3);
    cmp_cnt(end_cnt, 3);
    // released just past the end point: still a full result
    run_frame(5'h0D, 12'h3C3);
    cmp_vec(result_o, 12'h3C3);
    cmp_cnt(end_cnt, 4);
    cmp_cnt(abort_cnt, 0);
    run_frame(5'h0C, 12'h555);
    run_frame(5'h01, 12'h2AA);
    cmp_cnt(abort_cnt, 2);
    cmp_cnt(end_cnt, 4);
    cmp_bit(powered_down_o, 1'b0);
    foreach (pd_falls[k]) begin
      run_frame(5'h10, 12'h0F0);
      run_frame(pd_falls[k], 12'h0F0);
      cmp_bit(powered_down_o, 1'b1);
      run_frame(5'h0A, 12'h0F0);
      cmp_bit(powered_down_o, 1'b1);
      run_frame(5'h0B, 12'h0F0);
      cmp_bit(powered_down_o, 1'b0);
      cmp_bit(ready_o, 1'b0);
      wait_ready();
      run_frame(5'h10, 12'h0F0);
      run_frame(5'h10, 12'h9A6);
      cmp_vec(result_o, 12'h9A6);
    end
    finish_test();
  end
endmodule
